// >>> scf_pkg.sv
/*
  Shared constants and carrier types for the synthesizer calibration and
  front-end register bank: register offsets, field positions, reset values,
  state encodings and the packed structs that group related signals.
  Assumes one system clock domain and an internal register port fed by the
  serial control port decoder.
*/
package scf_pkg;

  // Register offsets on the internal register port.
  localparam logic [5:0] SCF_ADDR_RX_FRONT_END = 6'h21;
  localparam logic [5:0] SCF_ADDR_TX_FRONT_END = 6'h22;
  localparam logic [5:0] SCF_ADDR_CAL_HIGH     = 6'h23;
  localparam logic [5:0] SCF_ADDR_CAL_MID      = 6'h24;
  localparam logic [5:0] SCF_ADDR_CAL_LOW      = 6'h25;
  localparam logic [5:0] SCF_ADDR_CAL_CONTROL  = 6'h26;

  // Field positions (least significant bit of each field).
  localparam int SCF_POS_LO_DRIVE   = 4;
  localparam int SCF_POS_LEVEL_IDX  = 0;
  localparam int SCF_POS_CAL_CFG    = 6;
  localparam int SCF_POS_PUMP_EN    = 4;
  localparam int SCF_POS_RES_HIGH   = 0;

  // Reset values of every stored field.
  localparam logic [7:0] SCF_RST_RX_FRONT_END = 8'hA6;
  localparam logic [1:0] SCF_RST_LO_DRIVE     = 2'h1;
  localparam logic [2:0] SCF_RST_LEVEL_IDX    = 3'h0;
  localparam logic [1:0] SCF_RST_CAL_CFG      = 2'h2;
  localparam logic [1:0] SCF_RST_PUMP_EN      = 2'h2;
  localparam logic [3:0] SCF_RST_RES_HIGH     = 4'h9;
  localparam logic [5:0] SCF_RST_RES_MID      = 6'h0A;
  localparam logic [5:0] SCF_RST_RES_LOW      = 6'h20;
  localparam logic [6:0] SCF_RST_CAL_CONTROL  = 7'h0D;

  // Power ramp states.
  typedef enum logic [1:0] {
    SCF_RAMP_IDLE = 2'b00,
    SCF_RAMP_UP   = 2'b01,
    SCF_RAMP_HOLD = 2'b10,
    SCF_RAMP_DOWN = 2'b11
  } scf_ramp_state_t;

  // Synthesizer calibration sequence states.
  typedef enum logic [1:0] {
    SCF_CAL_IDLE = 2'b00,
    SCF_CAL_PUMP = 2'b01,
    SCF_CAL_VCO  = 2'b10
  } scf_cal_state_t;

  // One access on the internal register port.
  typedef struct packed {
    logic       wrEn;
    logic [5:0] addr;
    logic [7:0] wrData;
  } scf_reg_req_t;

  // One set of synthesizer calibration results.
  typedef struct packed {
    logic [3:0] high;
    logic [5:0] mid;
    logic [5:0] low;
  } scf_cal_result_t;

endpackage : scf_pkg

// >>> scf_synth_cal_frontend_regs.sv
/*
  Front-end and synthesizer calibration register bank with the output power
  ramp sequencer and the calibration stage sequencer that these registers steer.
  Assumes the serial control port decoder, the analog calibration engine and
  the transmit controller all run on sys_clk, so no input needs synchronising.
*/
`timescale 1ns/1ns
module scf_synth_cal_frontend_regs
  import scf_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  input  wire logic            clkEn,
  input  wire scf_reg_req_t    regReq,
  output logic [7:0]           regRdData,
  input  wire logic            txStart,
  input  wire logic            txEnd,
  input  wire logic            rampTick,
  output logic [2:0]           outputLevelTableIndex,
  output logic                 rampActive,
  input  wire logic            calStart,
  input  wire logic            calStageDone,
  input  wire scf_cal_result_t calResultIn,
  output logic                 pumpCalActive,
  output logic                 vcoCalActive,
  output logic                 calDone,
  output scf_cal_result_t      tuneValues,
  output logic [7:0]           rxFrontEndSetup,
  output logic [1:0]           txLoBufferDrive,
  output logic [1:0]           calConfig,
  output logic [6:0]           calControl
);

  // Stored register fields; reserved positions have no flip-flop at all.
  logic [7:0]      rxFrontEnd_reg;
  logic [7:0]      rxFrontEnd_next;
  logic [1:0]      loDrive_reg;
  logic [1:0]      loDrive_next;
  logic [2:0]      levelIdx_reg;
  logic [2:0]      levelIdx_next;
  logic [1:0]      calCfg_reg;
  logic [1:0]      calCfg_next;
  logic [1:0]      pumpEn_reg;
  logic [1:0]      pumpEn_next;
  scf_cal_result_t result_reg;
  scf_cal_result_t result_next;
  logic [6:0]      calCtrl_reg;
  logic [6:0]      calCtrl_next;
  logic [7:0]      rdData_reg;
  logic [7:0]      rdData_next;

  // Sequencer state.
  scf_ramp_state_t rampState_reg;
  scf_ramp_state_t rampState_next;
  logic [2:0]      rampIdx_reg;
  logic [2:0]      rampIdx_next;
  scf_cal_state_t  calState_reg;
  scf_cal_state_t  calState_next;
  logic            calDone_reg;
  logic            calDone_next;

  // Read-back view of one register; unmapped offsets read as zero.
  function automatic logic [7:0] readView(input logic [5:0] addr,
                                          input logic [7:0] rx,
                                          input logic [1:0] lo,
                                          input logic [2:0] lvl,
                                          input logic [1:0] cfg,
                                          input logic [1:0] pump,
                                          input scf_cal_result_t res,
                                          input logic [6:0] ctrl);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      SCF_ADDR_RX_FRONT_END: v = rx;
      SCF_ADDR_TX_FRONT_END: v = {2'b00, lo, 1'b0, lvl};
      SCF_ADDR_CAL_HIGH:     v = {cfg, pump, res.high};
      SCF_ADDR_CAL_MID:      v = {2'b00, res.mid};
      SCF_ADDR_CAL_LOW:      v = {2'b00, res.low};
      SCF_ADDR_CAL_CONTROL:  v = {1'b0, ctrl};
      default:               v = 8'h00;
    endcase
    return v;
  endfunction : readView

  // Register write decode, calibration result capture and read-back.
  always_comb
  begin
    rxFrontEnd_next = rxFrontEnd_reg;
    loDrive_next    = loDrive_reg;
    levelIdx_next   = levelIdx_reg;
    calCfg_next     = calCfg_reg;
    pumpEn_next     = pumpEn_reg;
    result_next     = result_reg;
    calCtrl_next    = calCtrl_reg;
    if (regReq.wrEn)
    begin
      unique case (regReq.addr)
        SCF_ADDR_RX_FRONT_END: rxFrontEnd_next = regReq.wrData;
        SCF_ADDR_TX_FRONT_END:
        begin
          loDrive_next  = regReq.wrData[SCF_POS_LO_DRIVE +: 2];
          levelIdx_next = regReq.wrData[SCF_POS_LEVEL_IDX +: 3];
        end
        SCF_ADDR_CAL_HIGH:
        begin
          calCfg_next      = regReq.wrData[SCF_POS_CAL_CFG +: 2];
          pumpEn_next      = regReq.wrData[SCF_POS_PUMP_EN +: 2];
          result_next.high = regReq.wrData[SCF_POS_RES_HIGH +: 4];
        end
        SCF_ADDR_CAL_MID:      result_next.mid = regReq.wrData[5:0];
        SCF_ADDR_CAL_LOW:      result_next.low = regReq.wrData[5:0];
        SCF_ADDR_CAL_CONTROL:  calCtrl_next = regReq.wrData[6:0];
        default:               ;
      endcase
    end
    // A finishing calibration wins over a host write to the result fields in the same cycle,
    // because the engine's fresh result must not be lost.
    // capture calibration results
    if (calState_reg == SCF_CAL_VCO && calStageDone)
    begin
      result_next = calResultIn;
    end
    rdData_next = readView(regReq.addr, rxFrontEnd_reg, loDrive_reg, levelIdx_reg,
                           calCfg_reg, pumpEn_reg, result_reg, calCtrl_reg);
  end

  // Register bank flip-flops; clkEn low freezes everything.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxFrontEnd_reg <= SCF_RST_RX_FRONT_END;
      loDrive_reg    <= SCF_RST_LO_DRIVE;
      levelIdx_reg   <= SCF_RST_LEVEL_IDX;
      calCfg_reg     <= SCF_RST_CAL_CFG;
      pumpEn_reg     <= SCF_RST_PUMP_EN;
      result_reg     <= '{high: SCF_RST_RES_HIGH, mid: SCF_RST_RES_MID,
                          low: SCF_RST_RES_LOW};
      calCtrl_reg    <= SCF_RST_CAL_CONTROL;
      rdData_reg     <= 8'h00;
    end
    else if (clkEn)
    begin
      rxFrontEnd_reg <= rxFrontEnd_next;
      loDrive_reg    <= loDrive_next;
      levelIdx_reg   <= levelIdx_next;
      calCfg_reg     <= calCfg_next;
      pumpEn_reg     <= pumpEn_next;
      result_reg     <= result_next;
      calCtrl_reg    <= calCtrl_next;
      rdData_reg     <= rdData_next;
    end
  end

  // Power ramp: walk the table index up on start and down on end.
  // The level is re-read every step, so a rewrite mid-ramp retargets it.
  always_comb
  begin
    rampState_next = rampState_reg;
    rampIdx_next   = rampIdx_reg;
    unique case (rampState_reg)
      SCF_RAMP_IDLE:
      begin
        if (txStart)
        begin
          rampIdx_next   = 3'h0;
          rampState_next = (levelIdx_reg == 3'h0) ? SCF_RAMP_HOLD : SCF_RAMP_UP;
        end
      end
      SCF_RAMP_UP:
      begin
        if (txEnd)
        begin
          rampState_next = SCF_RAMP_DOWN;
        end
        else if (rampTick)
        begin
          if (rampIdx_reg < levelIdx_reg)
          begin
            rampIdx_next = rampIdx_reg + 3'h1;
          end
          if (rampIdx_reg + 3'h1 >= levelIdx_reg)
          begin
            rampState_next = SCF_RAMP_HOLD;
          end
        end
      end
      SCF_RAMP_HOLD:
      begin
        rampIdx_next = levelIdx_reg;
        if (txEnd)
        begin
          rampState_next = SCF_RAMP_DOWN;
        end
      end
      SCF_RAMP_DOWN:
      begin
        if (rampTick)
        begin
          if (rampIdx_reg == 3'h0)
          begin
            rampState_next = SCF_RAMP_IDLE;
          end
          else
          begin
            rampIdx_next = rampIdx_reg - 3'h1;
          end
        end
      end
    endcase
  end

  // Ramp flip-flops.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rampState_reg <= SCF_RAMP_IDLE;
      rampIdx_reg   <= 3'h0;
    end
    else if (clkEn)
    begin
      rampState_reg <= rampState_next;
      rampIdx_reg   <= rampIdx_next;
    end
  end

  // Calibration stages: optional pump stage, then the oscillator stage.
  always_comb
  begin
    calState_next = calState_reg;
    calDone_next  = 1'b0;
    unique case (calState_reg)
      SCF_CAL_IDLE:
      begin
        if (calStart)
        begin
          calState_next = (pumpEn_reg == 2'h0) ? SCF_CAL_VCO : SCF_CAL_PUMP;
        end
      end
      SCF_CAL_PUMP:
      begin
        if (calStageDone)
        begin
          calState_next = SCF_CAL_VCO;
        end
      end
      SCF_CAL_VCO:
      begin
        if (calStageDone)
        begin
          calState_next = SCF_CAL_IDLE;
          calDone_next  = 1'b1;
        end
      end
      default: calState_next = SCF_CAL_IDLE;
    endcase
  end

  // Calibration flip-flops.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      calState_reg <= SCF_CAL_IDLE;
      calDone_reg  <= 1'b0;
    end
    else if (clkEn)
    begin
      calState_reg <= calState_next;
      calDone_reg  <= calDone_next;
    end
  end

  // Outputs; tuning always follows the stored results, host or engine.
  assign regRdData             = rdData_reg;
  assign outputLevelTableIndex = rampIdx_reg;
  assign rampActive            = (rampState_reg != SCF_RAMP_IDLE);
  assign pumpCalActive         = (calState_reg == SCF_CAL_PUMP);
  assign vcoCalActive          = (calState_reg == SCF_CAL_VCO);
  assign calDone               = calDone_reg;
  assign tuneValues            = result_reg;
  assign rxFrontEndSetup       = rxFrontEnd_reg;
  assign txLoBufferDrive       = loDrive_reg;
  assign calConfig             = calCfg_reg;
  assign calControl            = calCtrl_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_RX_WRITE: assert property (
    clkEn && regReq.wrEn && regReq.addr == SCF_ADDR_RX_FRONT_END
    |=> rxFrontEnd_reg == $past(regReq.wrData))
    else $error("Receive setup write not stored.");
  AST_TX_RSV_READ: assert property (
    clkEn && regReq.addr == SCF_ADDR_TX_FRONT_END
    |=> regRdData[7:6] == 2'b00 && regRdData[3] == 1'b0)
    else $error("Reserved transmit bits read nonzero.");
  AST_TX_WRITE: assert property (
    clkEn && regReq.wrEn && regReq.addr == SCF_ADDR_TX_FRONT_END
    |=> levelIdx_reg == $past(regReq.wrData[2:0])
        && txLoBufferDrive == $past(regReq.wrData[5:4]))
    else $error("Transmit setup write mishandled.");
  AST_CTRL_WRITE: assert property (
    clkEn && regReq.wrEn && regReq.addr == SCF_ADDR_CAL_CONTROL
    |=> calControl == $past(regReq.wrData[6:0]))
    else $error("Control field write not stored.");
  AST_RAMP_START: assert property (
    clkEn && rampState_reg == SCF_RAMP_IDLE && txStart
    |=> outputLevelTableIndex == 3'h0 && rampActive)
    else $error("Ramp did not start at entry zero.");
  AST_RAMP_STEP: assert property (
    clkEn && rampState_reg == SCF_RAMP_UP && rampTick && !txEnd
      && rampIdx_reg < levelIdx_reg
    |=> outputLevelTableIndex == $past(rampIdx_reg) + 3'h1)
    else $error("Ramp step wrong.");
  AST_PUMP_SKIP: assert property (
    clkEn && calState_reg == SCF_CAL_IDLE && calStart && pumpEn_reg == 2'h0
    |=> vcoCalActive && !pumpCalActive)
    else $error("Pump stage not skipped.");
  AST_RESULT_LOAD: assert property (
    clkEn && calState_reg == SCF_CAL_VCO && calStageDone
    |=> calDone && tuneValues == $past(calResultIn))
    else $error("Calibration result not captured.");
  AST_HOP_WRITE: assert property (
    clkEn && regReq.wrEn && regReq.addr == SCF_ADDR_CAL_MID
      && calState_reg == SCF_CAL_IDLE
    |=> tuneValues.mid == $past(regReq.wrData[5:0])
        && vcoCalActive == $past(calStart && pumpEn_reg == 2'h0))
    else $error("Hop value write not applied.");

  COV_FULL_RAMP: cover property (
    rampState_reg == SCF_RAMP_HOLD && levelIdx_reg == 3'h7);
  COV_PUMP_CAL: cover property (pumpCalActive ##[1:20] calDone);
  COV_SKIP_CAL: cover property (
    calState_reg == SCF_CAL_IDLE && calStart && pumpEn_reg == 2'h0);
  COV_RAMP_DOWN: cover property (rampState_reg == SCF_RAMP_DOWN ##[1:20] !rampActive);

endmodule : scf_synth_cal_frontend_regs

// >>> scf_cal_engine_model.sv
/*
  Behavioural model of the analog calibration engine that answers the
  register bank's stage requests with a done pulse and a result set.
  Assumes it shares sys_clk with the bank and drives on the falling edge.
*/
`timescale 1ns/1ns
module scf_cal_engine_model
  import scf_pkg::*;
#(
  parameter scf_cal_result_t RESULT = 16'h0000
)
(
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  input  wire logic [3:0]      stageDelay,
  input  wire logic            pumpCalActive,
  input  wire logic            vcoCalActive,
  output logic                 calStageDone,
  output scf_cal_result_t      calResultIn
);
  logic [3:0] stageCount;   // Cycles spent in the current stage.

  // Each stage finishes after stageDelay cycles, so tests can pick fast or slow.
  always @(negedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stageCount   <= 4'h0;
      calStageDone <= 1'b0;
    end
    else if (!(pumpCalActive || vcoCalActive))
    begin
      stageCount   <= 4'h0;
      calStageDone <= 1'b0;
    end
    else if (stageCount + 4'h1 == stageDelay)
    begin
      stageCount   <= 4'h0;
      calStageDone <= 1'b1;
    end
    else
    begin
      stageCount   <= stageCount + 4'h1;
      calStageDone <= 1'b0;
    end
  end

  // result with done
  // Outside the done pulse the result bus carries the inverted result, never the last value.
  assign calResultIn = calStageDone ? RESULT : ~RESULT;
endmodule : scf_cal_engine_model

// >>> testbench.sv
/*
  Self-checking testbench for the front-end and calibration register bank.
  Assumes read data follows the address by one enabled edge and drives every
  input on the falling edge of sys_clk.
*/
`timescale 1ns/1ns
module testbench;
  import scf_pkg::*;
  localparam scf_cal_result_t CAL_RES = {4'h5, 6'h2B, 6'h15};  // Engine answer.

  logic            sys_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            clkEn   = 1'b1;
  scf_reg_req_t    regReq  = '0;
  logic [7:0]      regRdData;
  logic            txStart = 1'b0;
  logic            txEnd   = 1'b0;
  logic            rampTick = 1'b0;
  logic [2:0]      outputLevelTableIndex;
  logic            rampActive;
  logic            calStart = 1'b0;
  logic            calStageDone;
  scf_cal_result_t calResultIn;
  logic            pumpCalActive;
  logic            vcoCalActive;
  logic            calDone;
  scf_cal_result_t tuneValues;
  logic [7:0]      rxFrontEndSetup;
  logic [1:0]      txLoBufferDrive;
  logic [1:0]      calConfig;
  logic [6:0]      calControl;
  logic [3:0]      stageDelay = 4'h3;
  int              miscompares = 0;
  int              comparisons = 0;
  int              cycleCount  = 0;
  logic [7:0]      rdExp [6] = '{8'hA6, 8'h10, 8'hA9, 8'h0A, 8'h20, 8'h0D};
  logic [7:0]      rdFull [6] = '{8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h3F, 8'h7F};

  always #5 sys_clk = ~sys_clk;

  scf_synth_cal_frontend_regs i_scf_synth_cal_frontend_regs (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .regReq(regReq),
    .regRdData(regRdData), .txStart(txStart), .txEnd(txEnd), .rampTick(rampTick),
    .outputLevelTableIndex(outputLevelTableIndex), .rampActive(rampActive),
    .calStart(calStart), .calStageDone(calStageDone), .calResultIn(calResultIn),
    .pumpCalActive(pumpCalActive), .vcoCalActive(vcoCalActive), .calDone(calDone),
    .tuneValues(tuneValues), .rxFrontEndSetup(rxFrontEndSetup),
    .txLoBufferDrive(txLoBufferDrive), .calConfig(calConfig), .calControl(calControl)
  );

  scf_cal_engine_model #(.RESULT(CAL_RES)) i_scf_cal_engine_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .stageDelay(stageDelay),
    .pumpCalActive(pumpCalActive), .vcoCalActive(vcoCalActive),
    .calStageDone(calStageDone), .calResultIn(calResultIn)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Compares a value seen at the ports with the expected one.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One write strobe, held for exactly one rising edge.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq.wrEn   = 1'b1;
    regReq.addr   = a;
    regReq.wrData = d;
    @(negedge sys_clk);
    regReq.wrEn = 1'b0;
  endtask : wr

  // Presents an address; read data is registered at the next rising edge.
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    regReq.addr = a;
    @(negedge sys_clk);
    chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, regRdData});
  endtask : rd

  // One-cycle pulse on a ramp or calibration input: 0 start, 1 end, 2 tick, 3 cal.
  task automatic pulse(input int which);
    @(negedge sys_clk);
    txStart  = (which == 0);
    txEnd    = (which == 1);
    rampTick = (which == 2);
    calStart = (which == 3);
    @(negedge sys_clk);
    {txStart, txEnd, rampTick, calStart} = 4'h0;
  endtask : pulse

  // Runs one calibration and waits a bounded time for its done pulse.
  task automatic run_cal(input logic pumpOn);
    pulse(3);
    chk("pump stage", {15'h0, pumpOn}, {15'h0, pumpCalActive});
    chk("vco stage", {15'h0, !pumpOn}, {15'h0, vcoCalActive});
    for (int i = 0; i < 60 && calDone !== 1'b1; i++)
      @(negedge sys_clk);
    chk("cal done", 16'h0001, {15'h0, calDone});
    chk("tune after cal", CAL_RES, tuneValues);
  endtask : run_cal

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge sys_clk)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    // Reset values, then an unmapped place, then outputs.
    for (int i = 0; i < 6; i++)
      rd(6'h21 + 6'(i), rdExp[i]);
    rd(6'h20, 8'h00);
    chk("tune reset", {4'h9, 6'h0A, 6'h20}, tuneValues);
    chk("drive reset", 16'h0001, {14'h0, txLoBufferDrive});
    chk("rx setup reset", 16'h00A6, {8'h0, rxFrontEndSetup});
    chk("cal config reset", 16'h0002, {14'h0, calConfig});
    $display("test reset values done");
    // All ones into every register: reserved bits must stay zero.
    for (int i = 0; i < 6; i++)
      wr(6'h21 + 6'(i), 8'hFF);
    for (int i = 0; i < 6; i++)
      rd(6'h21 + 6'(i), rdFull[i]);
    chk("tune hop", {4'hF, 6'h3F, 6'h3F}, tuneValues);
    chk("ctrl field", 16'h007F, {9'h0, calControl});
    chk("cal config ones", 16'h0003, {14'h0, calConfig});
    wr(6'h27, 8'h55);
    rd(6'h27, 8'h00);
    // A frozen clock enable must swallow the write.
    clkEn = 1'b0;
    wr(6'h21, 8'h12);
    clkEn = 1'b1;
    rd(6'h21, 8'hFF);
    chk("rx setup", 16'h00FF, {8'h0, rxFrontEndSetup});
    $display("test write and read-back done");
    // Ramp to level three and back.
    wr(6'h22, 8'h13);
    pulse(0);
    chk("ramp start", 16'h0010, {11'h0, rampActive, 1'b0, outputLevelTableIndex});
    for (int i = 1; i <= 3; i++)
    begin
      pulse(2);
      chk("ramp up", 16'(i), {13'h0, outputLevelTableIndex});
    end
    pulse(2);
    chk("hold", 16'h0003, {13'h0, outputLevelTableIndex});
    pulse(1);
    for (int i = 2; i >= 0; i--)
    begin
      pulse(2);
      chk("ramp down", 16'(i), {13'h0, outputLevelTableIndex});
    end
    pulse(2);
    chk("ramp idle", 16'h0000, {15'h0, rampActive});
    // Level zero skips the climb and holds entry zero at once.
    wr(6'h22, 8'h10);
    pulse(0);
    chk("zero hold", 16'h0010, {11'h0, rampActive, 1'b0, outputLevelTableIndex});
    pulse(1);
    pulse(2);
    chk("zero idle", 16'h0000, {15'h0, rampActive});
    $display("test ramp done");
    // Calibration with the pump stage, then with it disabled and a slow engine.
    wr(6'h23, 8'hA0);
    run_cal(1'b1);
    rd(6'h23, 8'hA5);
    rd(6'h24, 8'h2B);
    rd(6'h25, 8'h15);
    wr(6'h23, 8'h83);
    chk("tune hop high", {4'h3, 6'h2B, 6'h15}, tuneValues);
    chk("no cal on hop", 16'h0000, {14'h0, pumpCalActive, vcoCalActive});
    stageDelay = 4'h9;
    run_cal(1'b0);
    rd(6'h23, 8'h85);
    $display("test calibration done");
    // A second reset in mid-run must restore the receive setup, calibration and control fields the run changed.
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(6'h21, 8'hA6);
    rd(6'h23, 8'hA9);
    rd(6'h26, 8'h0D);
    chk("tune second reset", {4'h9, 6'h0A, 6'h20}, tuneValues);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : testbench
